// >>> src/uart_pkg.sv
// Shared types, constants and frame helpers for the serial channel
// Summary of operation
// - Sync mode sends on rising clock edges, samples on falling edges, LSB first.
// - At frame end the holding buffer moves to the shifter and sets empty flag.
// - Transmit-in-progress stays high until last bit sent and holding buffer empty.
// - Receiver shifts on falling edges, then buffers word and sets full flag.
// - Serial clock comes from the pin or from the baud generator, driven out.
// - Attention mode uses nine-bit frames; ninth bit one marks an address.
// - Waiting for address drops data characters; an address clears the wait bit.
// - Transmit ninth bit comes from config; received ninth bit shows in status.
// - Loop-back feeds the transmit shifter output straight into the receiver.
// - Seven/eight-bit frames: start, data, optional parity, one or two stops.
// - Nine-bit frames carry no parity; ninth bit uses its own control bits.
// - Baud clock comes from a five-bit prescaler then an eleven-bit divisor.
// - Prescale code zero stops; each code step adds a half to the factor.
// - Prescale code zero gates the channel off into its stopped state.
// - Transmit interrupt while buffer empty and its enable are set.
// - Receive interrupt while receive full and its enable are set.
// - Receive interrupt also on error flag with enable; status read clears error.
// - Flow interrupt on clear-to-send change with enable; control read clears it.
// - Transmit DMA requests on empty flag rising and masks transmit interrupt.
// - Receive DMA requests on full flag rising and masks full interrupt.
// - Second divider stage divides by divisor plus one.
// - Format 00 eight bits, 01 seven, 10 nine, 11 loop-back nine.
// - Synchronous operation exists only on channel zero.
package uart_pkg;
	localparam logic [1:0] FMT_8    = 2'h0;
	localparam logic [1:0] FMT_7    = 2'h1;
	localparam logic [1:0] FMT_9    = 2'h2;
	localparam logic [1:0] FMT_LOOP = 2'h3;
	localparam logic [1:0] PAR_ODD  = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_MARK = 2'h2;
	localparam int         FRAME_W  = 13;
	localparam int         RXBUF_DEPTH = 2;
	localparam logic       TBE_RESET = 1'b1;

	typedef struct packed {
		logic [1:0]  frame_format_field;
		logic        two_stop;
		logic        parity_enable_bit;
		logic [1:0]  parity_select;
		logic        tx_ninth_bit;
		logic [4:0]  prescale_select;
		logic [10:0] divisor_field;
		logic        sync_mode;
		logic        clk_internal;
		logic        tx_irq_enable;
		logic        rx_irq_enable;
		logic        error_irq_enable;
		logic        flow_irq_enable;
		logic        tx_dma_enable;
		logic        rx_dma_enable;
	} cfg_t;

	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tx_in_progress_flag;
		logic rx_full_flag;
		logic rx_error_flag;
		logic cts_change_flag;
		logic address_wait_bit;
		logic rx_ninth_bit;
	} status_t;

	function automatic logic [3:0] data_bits(input logic [1:0] fmt);
		return (fmt == FMT_8) ? 4'h8 : (fmt == FMT_7) ? 4'h7 : 4'h9;
	endfunction : data_bits

	function automatic logic par_on(input cfg_t c);
		return c.parity_enable_bit && !c.frame_format_field[1];
	endfunction : par_on

	function automatic logic [3:0] frame_bits(input cfg_t c);
		return 4'h2 + data_bits(c.frame_format_field) + {3'h0, par_on(c)} + {3'h0, c.two_stop};
	endfunction : frame_bits

	function automatic logic parity(input logic [8:0] d, input cfg_t c);
		logic x;
		x = ^d[6:0] ^ (d[7] & (c.frame_format_field == FMT_8));
		unique case (c.parity_select)
			PAR_ODD:  return ~x;
			PAR_EVEN: return x;
			PAR_MARK: return 1'b1;
			default:  return 1'b0;
		endcase
	endfunction : parity
endpackage : uart_pkg

// >>> src/uart_baud_gen.sv
// Two-stage baud divider with half-step prescaler
module uart_baud_gen
	import uart_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic [4:0]  i_prescale_select,
	input  wire logic [10:0] i_divisor_field,
	output logic             o_tick
);
	logic [5:0]  acc_q;
	logic [5:0]  acc_sum;
	logic        pre_tick;
	logic [10:0] div_q;

	// Factor (code+1)/2 by adding two per cycle against code+1
	assign acc_sum  = acc_q + 6'h2;
	assign pre_tick = (i_prescale_select != 5'h00) && (acc_sum >= {1'b0, i_prescale_select} + 6'h1);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || i_prescale_select == 5'h00) begin
			acc_q <= 6'h00;
		end else if (pre_tick) begin
			acc_q <= acc_sum - ({1'b0, i_prescale_select} + 6'h1);
		end else begin
			acc_q <= acc_sum;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || i_prescale_select == 5'h00) begin
			div_q <= 11'h000;
		end else if (pre_tick) begin
			div_q <= (div_q >= i_divisor_field) ? 11'h000 : div_q + 11'h001;
		end
	end

	assign o_tick = pre_tick && (div_q >= i_divisor_field);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	property p_no_clock;
		i_prescale_select == 5'h00 |-> !o_tick;
	endproperty
	a_no_clock: assert property (p_no_clock) else $error("tick while stopped");

	property p_div1_every;
		i_prescale_select == 5'h01 && i_divisor_field == 11'h000 && $stable(i_prescale_select)
			|-> o_tick;
	endproperty
	a_div1_every: assert property (p_div1_every) else $error("divide by one missed tick");
endmodule : uart_baud_gen

// >>> src/uart_rx_fifo.sv
// Small valid/ready buffer for received words
module uart_rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [WIDTH-1:0]      o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign o_ready = cnt_q != (AW+1)'(DEPTH);
	assign o_valid = cnt_q != '0;
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_data  = mem_q[rd_q];

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : nxt

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= nxt(wr_q);
			if (pop) rd_q <= nxt(rd_q);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : uart_rx_fifo

// >>> src/uart_sync_channel.sv
// Serial channel: sync transfer, attention, loop-back, interrupts, DMA
module uart_sync_channel
	import uart_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire cfg_t       i_cfg,
	input  wire logic       i_tx_wr,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_rx_rd,
	input  wire logic       i_stat_rd,
	input  wire logic       i_ictrl_rd,
	input  wire logic       i_addr_wait_set,
	input  wire logic       i_ser_clk,
	input  wire logic       i_rxd,
	input  wire logic       i_cts_n,
	output logic            o_ser_clk,
	output logic            o_ser_clk_oe,
	output logic            o_txd,
	output logic [7:0]      o_rx_data,
	output status_t         o_status,
	output logic            o_tx_irq,
	output logic            o_rx_irq,
	output logic            o_flow_irq,
	output logic            o_tx_dma_req,
	output logic            o_rx_dma_req
);
	logic              run;
	logic              sync_ok;
	logic              use_ext;
	logic              baud_tick;
	logic              int_clk_q;
	logic              ext_q1, ext_q2, ext_q3;
	logic              rxd_q1, rxd_q2;
	logic              cts_q1, cts_q2, cts_q3;
	logic              sclk_rise;
	logic              sclk_fall;
	logic [3:0]        fbits;
	logic [3:0]        nbits;
	logic              nine;
	logic [7:0]        hold_q;
	logic              tbe_q;
	logic              tbe_prev_q;
	logic [FRAME_W-1:0] tsh_q;
	logic [FRAME_W-1:0] tx_frame;
	logic [3:0]        tcnt_q;
	logic              tbusy_q;
	logic              tx_end;
	logic              tx_load;
	logic              rx_in;
	logic [FRAME_W-1:0] rsh_q;
	logic [3:0]        rcnt_q;
	logic              rbusy_q;
	logic              rx_commit;
	logic [8:0]        rx_word;
	logic              frame_err;
	logic              par_err;
	logic              is_addr;
	logic              accept;
	logic              push;
	logic              fifo_ready;
	logic              rx_full;
	logic              rbf_prev_q;
	logic [8:0]        fifo_out;
	logic              set_err;
	logic              err_q;
	logic              cts_chg_q;
	logic              addr_wait_q;

	// Clock source selection
	assign run     = i_cfg.prescale_select != 5'h00;
	assign sync_ok = (CHANNEL_INDEX == 0) && i_cfg.sync_mode;
	assign use_ext = sync_ok && !i_cfg.clk_internal;

	uart_baud_gen u_baud (
		.i_sys_clk         (i_sys_clk),
		.i_rstn            (i_rstn),
		.i_prescale_select (i_cfg.prescale_select),
		.i_divisor_field   (i_cfg.divisor_field),
		.o_tick            (baud_tick)
	);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !run) begin
			int_clk_q <= 1'b0;
		end else if (baud_tick) begin
			int_clk_q <= ~int_clk_q;
		end
	end

	// Pin synchronisers
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			{ext_q1, ext_q2, ext_q3} <= 3'h0;
			{rxd_q1, rxd_q2}         <= 2'h3;
			{cts_q1, cts_q2, cts_q3} <= 3'h7;
		end else begin
			{ext_q1, ext_q2, ext_q3} <= {i_ser_clk, ext_q1, ext_q2};
			{rxd_q1, rxd_q2}         <= {i_rxd, rxd_q1};
			{cts_q1, cts_q2, cts_q3} <= {i_cts_n, cts_q1, cts_q2};
		end
	end

	assign sclk_rise = run && (use_ext ? (ext_q2 && !ext_q3) : (baud_tick && !int_clk_q));
	assign sclk_fall = run && (use_ext ? (!ext_q2 && ext_q3) : (baud_tick && int_clk_q));

	assign o_ser_clk    = int_clk_q;
	assign o_ser_clk_oe = sync_ok && i_cfg.clk_internal && run;

	// Frame geometry
	assign nbits = data_bits(i_cfg.frame_format_field);
	assign nine  = i_cfg.frame_format_field[1];
	assign fbits = frame_bits(i_cfg);

	always_comb begin
		tx_frame    = '1;
		tx_frame[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nbits) tx_frame[i+1] = (i == 8) ? i_cfg.tx_ninth_bit : hold_q[i];
		end
		if (par_on(i_cfg)) tx_frame[nbits+4'h1] = parity({1'b0, hold_q}, i_cfg);
	end

	// Transmitter
	assign tx_end  = tbusy_q && sclk_rise && (tcnt_q == fbits);
	assign tx_load = sclk_rise && !tbe_q && (!tbusy_q || tx_end);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			hold_q <= 8'h00;
		end else if (i_tx_wr) begin
			hold_q <= i_tx_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			tbe_q <= TBE_RESET;
		end else if (i_tx_wr) begin
			tbe_q <= 1'b0;
		end else if (tx_load) begin
			tbe_q <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			tsh_q   <= '1;
			tcnt_q  <= 4'h0;
			tbusy_q <= 1'b0;
		end else if (tx_load) begin
			tsh_q   <= tx_frame;
			tcnt_q  <= 4'h1;
			tbusy_q <= 1'b1;
		end else if (tx_end) begin
			tsh_q   <= '1;
			tbusy_q <= 1'b0;
		end else if (tbusy_q && sclk_rise) begin
			tsh_q  <= {1'b1, tsh_q[FRAME_W-1:1]};
			tcnt_q <= tcnt_q + 4'h1;
		end
	end

	assign o_txd = tsh_q[0];

	// Receiver
	assign rx_in = (i_cfg.frame_format_field == FMT_LOOP) ? tsh_q[0] : rxd_q2;
	assign rx_commit = rbusy_q && (rcnt_q == fbits) && sclk_rise;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rsh_q   <= '1;
			rcnt_q  <= 4'h0;
			rbusy_q <= 1'b0;
		end else if (rx_commit) begin
			rbusy_q <= 1'b0;
		end else if (sclk_fall) begin
			if (!rbusy_q && !rx_in) begin
				rsh_q   <= {{(FRAME_W-1){1'b1}}, 1'b0};
				rcnt_q  <= 4'h1;
				rbusy_q <= 1'b1;
			end else if (rbusy_q && rcnt_q < fbits) begin
				rsh_q[rcnt_q] <= rx_in;
				rcnt_q        <= rcnt_q + 4'h1;
			end
		end
	end

	always_comb begin
		rx_word = 9'h000;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nbits) rx_word[i] = rsh_q[i+1];
		end
		frame_err = !rsh_q[fbits-4'h1] || (i_cfg.two_stop && !rsh_q[fbits-4'h2]);
		par_err   = par_on(i_cfg) && (rsh_q[nbits+4'h1] != parity(rx_word, i_cfg));
	end

	assign is_addr = nine && rx_word[8];
	assign accept  = !addr_wait_q || is_addr;
	assign push    = rx_commit && accept;
	assign set_err = push && (frame_err || par_err || !fifo_ready);

	uart_rx_fifo #(
		.WIDTH (9),
		.DEPTH (RXBUF_DEPTH)
	) u_rxbuf (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_valid   (push),
		.o_ready   (fifo_ready),
		.i_data    (rx_word),
		.o_valid   (rx_full),
		.i_ready   (i_rx_rd),
		.o_data    (fifo_out)
	);

	assign o_rx_data = fifo_out[7:0];

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			addr_wait_q <= 1'b0;
		end else if (rx_commit && is_addr && addr_wait_q) begin
			addr_wait_q <= 1'b0;
		end else if (i_addr_wait_set) begin
			addr_wait_q <= 1'b1;
		end
	end

	// Sticky flags, set beats clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			err_q <= 1'b0;
		end else if (set_err) begin
			err_q <= 1'b1;
		end else if (i_stat_rd) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			cts_chg_q <= 1'b0;
		end else if (cts_q2 != cts_q3) begin
			cts_chg_q <= 1'b1;
		end else if (i_ictrl_rd) begin
			cts_chg_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			tbe_prev_q <= TBE_RESET;
			rbf_prev_q <= 1'b0;
		end else begin
			tbe_prev_q <= tbe_q;
			rbf_prev_q <= rx_full;
		end
	end

	// Interrupts and DMA
	assign o_tx_irq     = tbe_q && i_cfg.tx_irq_enable && !i_cfg.tx_dma_enable;
	assign o_rx_irq     = (rx_full && i_cfg.rx_irq_enable && !i_cfg.rx_dma_enable)
		|| (err_q && i_cfg.error_irq_enable);
	assign o_flow_irq   = cts_chg_q && i_cfg.flow_irq_enable;
	assign o_tx_dma_req = i_cfg.tx_dma_enable && tbe_q && !tbe_prev_q;
	assign o_rx_dma_req = i_cfg.rx_dma_enable && rx_full && !rbf_prev_q;

	assign o_status = '{
		tx_buffer_empty_flag: tbe_q,
		tx_in_progress_flag:  tbusy_q || !tbe_q,
		rx_full_flag:         rx_full,
		rx_error_flag:        err_q,
		cts_change_flag:      cts_chg_q,
		address_wait_bit:     addr_wait_q,
		rx_ninth_bit:         fifo_out[8]
	};

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_load;
		tx_load && !i_tx_wr;
	endsequence
	sequence s_start_out;
		!o_txd && tbe_q && tbusy_q;
	endsequence

	property p_tx_start;
		s_load |=> s_start_out;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("load did not start frame");

	property p_txd_on_rise;
		$changed(o_txd) |-> $past(sclk_rise);
	endproperty
	a_txd_on_rise: assert property (p_txd_on_rise) else $error("txd moved off rising edge");

	property p_wr_clears;
		i_tx_wr |=> !tbe_q ##1 (!tbe_q || $past(tx_load));
	endproperty
	a_wr_clears: assert property (p_wr_clears) else $error("write left buffer empty");

	property p_inprog_fall;
		$fell(o_status.tx_in_progress_flag) |-> $past(tx_end) && tbe_q;
	endproperty
	a_inprog_fall: assert property (p_inprog_fall) else $error("in-progress dropped early");

	property p_rx_full;
		push && fifo_ready |=> rx_full;
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("word not buffered");

	property p_attn_drop;
		rx_commit && addr_wait_q && !is_addr && !rx_full |=> !rx_full;
	endproperty
	a_attn_drop: assert property (p_attn_drop) else $error("data kept while waiting");

	property p_attn_clear;
		rx_commit && addr_wait_q && is_addr |=> !addr_wait_q && rx_full;
	endproperty
	a_attn_clear: assert property (p_attn_clear) else $error("address not taken");

	property p_tx_dma_pulse;
		o_tx_dma_req |=> !o_tx_dma_req && !o_tx_irq[*2];
	endproperty
	a_tx_dma_pulse: assert property (p_tx_dma_pulse) else $error("tx dma not one pulse");

	property p_err_sticky;
		set_err |=> err_q;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

	property p_stopped;
		!run |=> !tbusy_q || $stable(tsh_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("shifted while stopped");

	property p_flow_clear;
		i_ictrl_rd && cts_q2 == cts_q3 |=> !cts_chg_q;
	endproperty
	a_flow_clear: assert property (p_flow_clear) else $error("cts change not cleared");

	property p_dma_masks_rx;
		i_cfg.rx_dma_enable && !(err_q && i_cfg.error_irq_enable) |-> !o_rx_irq;
	endproperty
	a_dma_masks_rx: assert property (p_dma_masks_rx) else $error("rx irq with rx dma");
endmodule : uart_sync_channel

// >>> sim/serial_peer.sv
// Remote serial node: runs the link clock during frames and trades bits
module serial_peer (
	input  wire logic i_sys_clk,
	input  wire logic i_txd,
	output logic      o_sclk,
	output logic      o_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 8;

	initial begin
		o_sclk = 1'b0;
		o_rxd  = 1'b1;
	end

	// Clock low between frames; drive on rise, sample on fall, LSB first
	task automatic xfer(input logic [31:0] f, input int m, output logic [31:0] got);
		int k;
		got = 32'hFFFF_FFFF;
		for (k = 0; k < m; k++) begin
			@(posedge i_sys_clk);
			o_sclk <= 1'b1;
			o_rxd  <= f[k];
			repeat (HALF) @(posedge i_sys_clk);
			o_sclk <= 1'b0;
			got[k] = i_txd;
			repeat (HALF - 1) @(posedge i_sys_clk);
		end
	endtask : xfer
endmodule : serial_peer

// >>> sim/tb_top.sv
// Self-checking bench for the serial channel
module tb_top
	import uart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rstn, cts_n, ser_clk, oe, txd, tx_irq, rx_irq, flow_irq, tdma, rdma;
	logic        p_clk, p_rxd;
	logic [4:0]  stb;
	logic [7:0]  tx_data, rx_data;
	logic [31:0] got, seed, r;
	logic [4:0]  pcode [4] = '{5'h01, 5'h02, 5'h05, 5'h1F};
	cfg_t        cfg, c;
	status_t     st;
	int          fails, checked, cyc, ntx, nrx, i, t0, t1;
	wire logic   pin = oe ? ser_clk : p_clk;

	uart_sync_channel i_dut (
		.i_sys_clk(sys_clk), .i_rstn(rstn), .i_cfg(cfg), .i_tx_wr(stb[0]),
		.i_tx_data(tx_data), .i_rx_rd(stb[1]), .i_stat_rd(stb[2]), .i_ictrl_rd(stb[3]),
		.i_addr_wait_set(stb[4]), .i_ser_clk(pin), .i_rxd(p_rxd), .i_cts_n(cts_n),
		.o_ser_clk(ser_clk), .o_ser_clk_oe(oe), .o_txd(txd), .o_rx_data(rx_data),
		.o_status(st), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq), .o_flow_irq(flow_irq),
		.o_tx_dma_req(tdma), .o_rx_dma_req(rdma)
	);

	serial_peer i_peer (.i_sys_clk(sys_clk), .i_txd(txd), .o_sclk(p_clk), .o_rxd(p_rxd));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		ntx <= ntx + int'(tdma === 1'b1);
		nrx <= nrx + int'(rdma === 1'b1);
		if (cyc == 40000) begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize;
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic int nd(input cfg_t k);
		return k.frame_format_field == FMT_8 ? 8 : k.frame_format_field == FMT_7 ? 7 : 9;
	endfunction : nd

	function automatic int flen(input cfg_t k);
		return 2 + nd(k) + int'(k.parity_enable_bit & ~k.frame_format_field[1]) + int'(k.two_stop);
	endfunction : flen

	function automatic logic [31:0] msk(input int n);
		return ~(32'hFFFF_FFFF << n);
	endfunction : msk

	// Expected line bits: start, data, parity, stops, idle ones after
	function automatic logic [31:0] mk(input logic [8:0] d, input cfg_t k);
		logic [31:0] f;
		logic        x;
		int          j;
		f = 32'hFFFF_FFFE;
		x = 1'b0;
		for (j = 0; j < nd(k); j++) begin
			f[j+1] = d[j];
			x ^= d[j];
		end
		if (k.parity_enable_bit && !k.frame_format_field[1]) begin
			f[nd(k)+1] = k.parity_select == PAR_ODD ? ~x : k.parity_select == PAR_EVEN ? x :
				k.parity_select == PAR_MARK;
		end
		return f;
	endfunction : mk

	task automatic strobe(input int w);
		@(posedge sys_clk);
		stb[w] <= 1'b1;
		@(posedge sys_clk);
		stb <= 5'h00;
		repeat (3) @(posedge sys_clk);
	endtask : strobe

	task automatic xf(input logic [31:0] f, input int m);
		i_peer.xfer(f, m, got);
		repeat (4) @(posedge sys_clk);
	endtask : xf

	task automatic wait_rise(output int t);
		logic p;
		int   k;
		p = ser_clk;
		for (k = 0; k < 400; k++) begin
			@(posedge sys_clk);
			if (ser_clk === 1'b1 && p === 1'b0) break;
			p = ser_clk;
		end
		t = cyc;
	endtask : wait_rise

	task automatic rx_check(input logic [8:0] d);
		chk("rx_full", st.rx_full_flag, 1);
		chk("rx_data", rx_data, d[7:0]);
		chk("rx_ninth", st.rx_ninth_bit & c.frame_format_field[1], d[8]);
		chk("rx_irq", rx_irq, c.rx_irq_enable & ~c.rx_dma_enable);
		strobe(1);
		chk("rx_empty", st.rx_full_flag, 0);
		chk("rx_irq_off", rx_irq, 0);
	endtask : rx_check

	task automatic one_frame(input logic [7:0] b, input logic [8:0] d);
		int n;
		int a;
		int q;
		n = flen(c);
		a = ntx;
		q = nrx;
		d = d & ~(9'h1FF << nd(c));
		tx_data <= b;
		strobe(0);
		chk("tbe", st.tx_buffer_empty_flag, 0);
		chk("xmip", st.tx_in_progress_flag, 1);
		chk("tx_irq", tx_irq, 0);
		xf(mk(d, c), n + 1);
		chk("frame", got & msk(n + 1), mk({c.tx_ninth_bit, b}, c) & msk(n + 1));
		chk("tbe_set", st.tx_buffer_empty_flag, 1);
		chk("xmip_end", st.tx_in_progress_flag, 0);
		chk("tx_irq_on", tx_irq, c.tx_irq_enable & ~c.tx_dma_enable);
		chk("tx_dma", ntx - a, c.tx_dma_enable);
		chk("rx_dma", nrx - q, c.rx_dma_enable);
		chk("oe_ext", oe, 0);
		rx_check(d);
	endtask : one_frame

	initial begin
		seed = 32'h0000_B58F;
		rstn = 1'b0;
		stb = 5'h00;
		tx_data = 8'h00;
		cts_n = 1'b1;
		c = '0;
		cfg = '0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("tbe_rst", st.tx_buffer_empty_flag, 1);
		chk("xmip_rst", st.tx_in_progress_flag, 0);
		chk("txd_idle", txd, 1);
		chk("cts_rst", st.cts_change_flag, 0);
		c.sync_mode = 1'b1;
		c.prescale_select = 5'h01;
		for (i = 0; i < 12; i++) begin
			r = rnd();
			c.frame_format_field = (i < 4) ? {1'b0, i[0]} : 2'(i % 3);
			c.parity_enable_bit = (i < 4) | r[0];
			c.parity_select = (i < 4) ? i[1:0] : r[2:1];
			c.two_stop = r[3];
			c.tx_ninth_bit = r[4];
			c.tx_dma_enable = r[5];
			c.rx_dma_enable = r[6];
			c.rx_irq_enable = r[7];
			c.tx_irq_enable = 1'b1;
			cfg <= c;
			one_frame(r[15:8], r[24:16]);
		end
		c.frame_format_field = FMT_8;
		c.parity_enable_bit = 1'b0;
		c.two_stop = 1'b0;
		cfg <= c;
		tx_data <= 8'hA5;
		strobe(0);
		fork
			xf(32'hFFFF_FFFF, 21);
			begin
				repeat (40) @(posedge sys_clk);
				tx_data <= 8'h3C;
				strobe(0);
				chk("b2b_tbe", st.tx_buffer_empty_flag, 0);
				repeat (130) @(posedge sys_clk);
				chk("b2b_xmip", st.tx_in_progress_flag, 1);
			end
		join
		chk("b2b", got & msk(21), (mk(9'h03C, c) << 10 | mk(9'h0A5, c) & msk(10)) & msk(21));
		chk("b2b_end", st.tx_in_progress_flag, 0);
		c.frame_format_field = FMT_9;
		c.rx_dma_enable = 1'b0;
		cfg <= c;
		strobe(4);
		chk("wait_set", st.address_wait_bit, 1);
		xf(mk(9'h055, c), flen(c) + 1);
		chk("drop", st.rx_full_flag, 0);
		chk("still_wait", st.address_wait_bit, 1);
		xf(mk(9'h1C3, c), flen(c) + 1);
		chk("wait_clr", st.address_wait_bit, 0);
		rx_check(9'h1C3);
		xf(mk(9'h07E, c), flen(c) + 1);
		rx_check(9'h07E);
		c.frame_format_field = FMT_7;
		c.parity_enable_bit = 1'b1;
		c.parity_select = PAR_EVEN;
		c.rx_irq_enable = 1'b0;
		c.error_irq_enable = 1'b1;
		c.rx_dma_enable = 1'b1;
		c.flow_irq_enable = 1'b1;
		cfg <= c;
		xf(mk(9'h02D, c) ^ 32'h0000_0100, flen(c) + 1);
		chk("err", st.rx_error_flag, 1);
		chk("err_irq", rx_irq, 1);
		strobe(2);
		chk("err_clr", st.rx_error_flag, 0);
		chk("err_irq_off", rx_irq, 0);
		xf(mk(9'h011, c), flen(c) + 1);
		chk("no_ovr", st.rx_error_flag, 0);
		xf(mk(9'h022, c), flen(c) + 1);
		chk("ovr", st.rx_error_flag, 1);
		strobe(2);
		strobe(1);
		chk("ovr_head", rx_data, 8'h11);
		strobe(1);
		chk("ovr_drop", st.rx_full_flag, 0);
		cts_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("cts", st.cts_change_flag, 1);
		chk("flow_irq", flow_irq, 1);
		strobe(3);
		chk("cts_clr", st.cts_change_flag, 0);
		chk("flow_off", flow_irq, 0);
		cts_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		strobe(3);
		c.clk_internal = 1'b1;
		c.prescale_select = 5'h00;
		cfg <= c;
		wait_rise(t0);
		wait_rise(t1);
		chk("clk_stop", t1 - t0, 400);
		for (i = 0; i < 4; i++) begin
			c.prescale_select = 5'h00;
			cfg <= c;
			@(posedge sys_clk);
			c.prescale_select = pcode[i];
			c.divisor_field = 11'(i);
			cfg <= c;
			wait_rise(t0);
			wait_rise(t0);
			wait_rise(t1);
			wait_rise(t1);
			chk("baud", t1 - t0, 2 * (pcode[i] + 1) * (i + 1));
		end
		c.prescale_select = 5'h00;
		cfg <= c;
		@(posedge sys_clk);
		c.frame_format_field = FMT_LOOP;
		c.prescale_select = 5'h02;
		c.divisor_field = 11'h000;
		c.tx_ninth_bit = 1'b1;
		c.rx_dma_enable = 1'b0;
		c.rx_irq_enable = 1'b1;
		cfg <= c;
		repeat (2) @(posedge sys_clk);
		chk("oe_int", oe, 1);
		tx_data <= 8'h96;
		strobe(0);
		for (i = 0; i < 500 && st.rx_full_flag !== 1'b1; i++) begin
			@(posedge sys_clk);
		end
		repeat (2) @(posedge sys_clk);
		rx_check(9'h196);
		summarize();
	end
endmodule : tb_top
